// ==== logic/bfu_mem.sv ====
// small register array with one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
module bfu_mem #(
    parameter int unsigned WIDTH = 8,                   // word width
    parameter int unsigned DEPTH = 32,                  // number of words
    parameter int unsigned AW    = 5                    // address width
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             we_i,                 // write strobe
    input  wire logic [AW-1:0]    waddr_i,              // write address
    input  wire logic [WIDTH-1:0] wdata_i,              // write data
    input  wire logic [AW-1:0]    raddr_a_i,            // operand read address
    output logic      [WIDTH-1:0] rdata_a_o,            // operand read data
    input  wire logic [AW-1:0]    raddr_b_i,            // bus read address
    output logic      [WIDTH-1:0] rdata_b_o             // bus read data
);

    // depth must fit the address
    if (DEPTH > (1 << AW)) begin : g_chk
        $error("bfu_mem depth exceeds address range");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];                    // storage words

    // write port, cleared on reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // read ports, the caller registers them
    assign rdata_a_o = mem_q[raddr_a_i];
    assign rdata_b_o = mem_q[raddr_b_i];

endmodule : bfu_mem
`default_nettype wire

// ==== logic/bfu_pkg.sv ====
// shared constants and types of the bit and flag instruction unit
package bfu_pkg;

    // data and address widths
    localparam int unsigned DATA_W   = 8;               // register and bus width
    localparam int unsigned RSEL_W   = 5;               // register file index width
    localparam int unsigned BSEL_W   = 3;               // bit index width
    localparam int unsigned BADDR_W  = 8;               // bus address width
    localparam int unsigned CNT_W    = 4;               // access cycle counter width
    localparam int unsigned BASE_W   = 2;               // listed access cycle count width

    // bus map
    localparam logic [7:0] GPR_BASE  = 8'h00;           // 32 working registers
    localparam logic [7:0] IO_BASE   = 8'h20;           // 32 bit addressable i/o bytes
    localparam logic [7:0] FLAG_ADDR = 8'h40;           // core_flag_register
    localparam logic [7:0] STAT_ADDR = 8'h41;           // unit status
    localparam logic [2:0] SPACE_LSB = 3'h5;            // space select starts above bit 4

    // reset values
    localparam logic [7:0] FLAG_RST  = 8'h00;           // all flags clear
    localparam logic [7:0] DATA_RST  = 8'h00;           // data registers clear

    // flag positions in core_flag_register
    localparam logic [2:0] FLAG_C    = 3'h0;            // carry
    localparam logic [2:0] FLAG_Z    = 3'h1;            // zero
    localparam logic [2:0] FLAG_N    = 3'h2;            // negative
    localparam logic [2:0] FLAG_V    = 3'h3;            // two's complement overflow
    localparam logic [2:0] FLAG_S    = 3'h4;            // signed test
    localparam logic [2:0] FLAG_H    = 3'h5;            // half carry
    localparam logic [2:0] FLAG_T    = 3'h6;            // transfer bit
    localparam logic [2:0] FLAG_I    = 3'h7;            // global interrupt enable

    // status register fields
    localparam logic [2:0] STAT_READY = 3'h0;           // unit can take an operation
    localparam logic [2:0] STAT_BUSY  = 3'h1;           // data access still counting

    // access targets
    typedef enum logic [1:0] {
        TGT_INTERNAL = 2'b00,                           // registers and i/o space
        TGT_SRAM     = 2'b01,                           // internal static ram
        TGT_EXTERNAL = 2'b10                            // external ram interface
    } bfu_target_t;

    // operation codes
    typedef enum logic [4:0] {
        NOP_OP                 = 5'h00,
        ROTATE_RIGHT_CARRY_OP  = 5'h01,
        ARITH_SHIFT_RIGHT_OP   = 5'h02,
        NIBBLE_SWAP_OP         = 5'h03,
        IO_BIT_SET_OP          = 5'h04,
        IO_BIT_CLEAR_OP        = 5'h05,
        BIT_TO_TRANSFER_OP     = 5'h06,
        TRANSFER_TO_BIT_OP     = 5'h07,
        FLAG_SET_OP            = 5'h08,
        FLAG_CLEAR_OP          = 5'h09,
        OVERFLOW_SET_OP        = 5'h0a,
        OVERFLOW_CLEAR_OP      = 5'h0b,
        HALF_CARRY_SET_OP      = 5'h0c,
        HALF_CARRY_CLEAR_OP    = 5'h0d,
        SIGNED_TEST_SET_OP     = 5'h0e,
        SIGNED_TEST_CLEAR_OP   = 5'h0f,
        DATA_ACCESS_OP         = 5'h10
    } bfu_op_t;

    // shift unit selections
    typedef enum logic [1:0] {
        SH_ROR  = 2'b00,                                // rotate right through carry
        SH_ASR  = 2'b01,                                // arithmetic shift right
        SH_SWAP = 2'b10                                 // nibble swap
    } bfu_shsel_t;

endpackage : bfu_pkg

// ==== logic/bfu_shift.sv ====
// rotate, shift and swap datapath with flag results
`timescale 1ns/1ps
`default_nettype none
module bfu_shift (
    input  wire logic              [7:0] opnd_i,        // destination register value
    input  wire logic                    carry_i,       // old carry flag
    input  wire bfu_pkg::bfu_shsel_t     sel_i,         // which operation
    output logic                   [7:0] res_o,         // result byte
    output logic                         c_o,           // new carry
    output logic                         z_o,           // new zero
    output logic                         n_o,           // new negative
    output logic                         v_o            // new overflow
);

    // result and flags of the selected operation
    always_comb begin
        res_o = opnd_i;
        c_o   = opnd_i[0];                              // old bit 0 drops into carry
        case (sel_i)
            bfu_pkg::SH_ROR:  res_o = {carry_i, opnd_i[7:1]};
            bfu_pkg::SH_ASR:  res_o = {opnd_i[7], opnd_i[7:1]};
            bfu_pkg::SH_SWAP: res_o = {opnd_i[3:0], opnd_i[7:4]};
            default:          res_o = opnd_i;
        endcase
        z_o = (res_o == 8'h00);
        n_o = res_o[7];
        v_o = n_o ^ c_o;                                // overflow is negative xor carry
    end

endmodule : bfu_shift
`default_nettype wire

// ==== logic/bfu_top.sv ====
// bit and flag instruction unit: shifts, bit moves, flag ops, access timing
`timescale 1ns/1ps
`default_nettype none
module bfu_top #(
    parameter int unsigned EXT_EXTRA_CYCLES = 2         // extra cycles on external ram
) (
    input  wire logic                  CLK_I,
    input  wire logic                  RESET_I,
    // operation port
    input  wire logic                  OP_VALID_I,      // operation offered
    input  wire bfu_pkg::bfu_op_t      OP_CODE_I,       // operation code
    input  wire logic            [4:0] REG_SEL_I,       // working register index
    input  wire logic            [2:0] BIT_SEL_I,       // bit or flag index
    input  wire logic            [4:0] IO_ADDR_I,       // i/o byte index
    input  wire logic            [1:0] ACC_BASE_I,      // listed access cycles
    input  wire bfu_pkg::bfu_target_t  ACC_TGT_I,       // access target
    output logic                       READY_O,         // operation may be offered
    output logic                       DONE_O,          // operation finished pulse
    output logic                 [7:0] RESULT_O,        // last byte written
    output logic                 [7:0] FLAGS_O,         // core_flag_register
    // register bus
    input  wire logic            [7:0] ADDR_I,          // byte address
    input  wire logic            [7:0] WDATA_I,         // write data
    input  wire logic                  WR_I,            // write strobe
    input  wire logic                  RD_I,            // read strobe
    output logic                 [7:0] RDATA_O          // read data, cycle after strobe
);

    // counter must hold the longest access
    if (EXT_EXTRA_CYCLES + 4 > (1 << bfu_pkg::CNT_W) - 1) begin : g_chk
        $error("bfu_top EXT_EXTRA_CYCLES too large for counter");
    end

    localparam logic [bfu_pkg::CNT_W-1:0] EXT_EXTRA =
        bfu_pkg::CNT_W'(EXT_EXTRA_CYCLES);               // external extra cycles
    localparam logic [bfu_pkg::CNT_W-1:0] SRAM_EXTRA =
        bfu_pkg::CNT_W'(1);                              // internal sram extra cycle
    localparam logic [bfu_pkg::CNT_W-1:0] CNT_ONE =
        bfu_pkg::CNT_W'(1);                              // unit step

    // all state of the unit
    typedef struct packed {
        logic [7:0]                flags;               // core_flag_register
        logic                      busy;                // data access counting
        logic [bfu_pkg::CNT_W-1:0] rem;                 // cycles left in access
        logic                      ready;               // mirrors not busy
        logic                      done;                // finish pulse
        logic [7:0]                result;              // last written byte
        logic [7:0]                rdata;               // bus read data
    } bfu_state_t;

    bfu_state_t s_q;                                    // registered state
    bfu_state_t s_d;                                    // next state

    // memory and shifter wiring
    logic       [7:0] gpr_opnd;                         // operand register
    logic       [7:0] gpr_bus;                          // register seen by bus
    logic       [7:0] io_opnd;                          // operand i/o byte
    logic       [7:0] io_bus;                           // i/o byte seen by bus
    logic             gpr_we;                           // register file write
    logic       [4:0] gpr_wa;                           // register file address
    logic       [7:0] gpr_wd;                           // register file data
    logic             io_we;                            // i/o write
    logic       [4:0] io_wa;                            // i/o address
    logic       [7:0] io_wd;                            // i/o data
    logic       [7:0] sh_res;                           // shifter result
    logic             sh_c;                             // shifter carry
    logic             sh_z;                             // shifter zero
    logic             sh_n;                             // shifter negative
    logic             sh_v;                             // shifter overflow
    bfu_pkg::bfu_shsel_t sh_sel;                        // shifter selection

    // decoded bus and operation terms
    logic             take;                             // operation accepted
    logic       [2:0] space;                            // address space select
    logic             bus_gpr;                          // bus hits registers
    logic             bus_io;                           // bus hits i/o space
    logic [bfu_pkg::CNT_W-1:0] acc_cnt;                 // cycles of this access

    // an op offered while a long access counts is dropped, not queued
    // the two memory spaces decode on the top three address bits only;
    // flag and status bytes match the full address
    assign take    = OP_VALID_I && !s_q.busy;
    assign space   = ADDR_I[7:bfu_pkg::SPACE_LSB];
    assign bus_gpr = (space == bfu_pkg::GPR_BASE[7:bfu_pkg::SPACE_LSB]);
    assign bus_io  = (space == bfu_pkg::IO_BASE[7:bfu_pkg::SPACE_LSB]);

    // shifter selection from the operation code
    always_comb begin
        case (OP_CODE_I)
            bfu_pkg::ARITH_SHIFT_RIGHT_OP: sh_sel = bfu_pkg::SH_ASR;
            bfu_pkg::NIBBLE_SWAP_OP:       sh_sel = bfu_pkg::SH_SWAP;
            default:                       sh_sel = bfu_pkg::SH_ROR;
        endcase
    end

    // access length by target
    always_comb begin
        acc_cnt = bfu_pkg::CNT_W'(ACC_BASE_I);
        case (ACC_TGT_I)
            bfu_pkg::TGT_SRAM:     acc_cnt = acc_cnt + SRAM_EXTRA;
            bfu_pkg::TGT_EXTERNAL: acc_cnt = acc_cnt + EXT_EXTRA;
            default:               acc_cnt = acc_cnt;
        endcase
    end

    // working registers
    bfu_mem #(.WIDTH(8), .DEPTH(32), .AW(5)) u_gpr (
        .clk_i     (CLK_I),
        .rst_i     (RESET_I),
        .we_i      (gpr_we),
        .waddr_i   (gpr_wa),
        .wdata_i   (gpr_wd),
        .raddr_a_i (REG_SEL_I),
        .rdata_a_o (gpr_opnd),
        .raddr_b_i (ADDR_I[4:0]),
        .rdata_b_o (gpr_bus)
    );

    // bit addressable i/o bytes
    bfu_mem #(.WIDTH(8), .DEPTH(32), .AW(5)) u_io (
        .clk_i     (CLK_I),
        .rst_i     (RESET_I),
        .we_i      (io_we),
        .waddr_i   (io_wa),
        .wdata_i   (io_wd),
        .raddr_a_i (IO_ADDR_I),
        .rdata_a_o (io_opnd),
        .raddr_b_i (ADDR_I[4:0]),
        .rdata_b_o (io_bus)
    );

    // rotate, shift and swap
    bfu_shift u_shift (
        .opnd_i  (gpr_opnd),
        .carry_i (s_q.flags[bfu_pkg::FLAG_C]),
        .sel_i   (sh_sel),
        .res_o   (sh_res),
        .c_o     (sh_c),
        .z_o     (sh_z),
        .n_o     (sh_n),
        .v_o     (sh_v)
    );

    // next state, memory writes and bus answers
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        // bus writes land unless an operation writes the same space
        gpr_we   = WR_I && bus_gpr;
        gpr_wa   = ADDR_I[4:0];
        gpr_wd   = WDATA_I;
        io_we    = WR_I && bus_io;
        io_wa    = ADDR_I[4:0];
        io_wd    = WDATA_I;
        if (WR_I && (ADDR_I == bfu_pkg::FLAG_ADDR)) begin
            s_d.flags = WDATA_I;
        end
        // bus read, answered next cycle, unmapped reads zero
        if (RD_I) begin
            if (bus_gpr) begin
                s_d.rdata = gpr_bus;
            end else if (bus_io) begin
                s_d.rdata = io_bus;
            end else if (ADDR_I == bfu_pkg::FLAG_ADDR) begin
                s_d.rdata = s_q.flags;
            end else if (ADDR_I == bfu_pkg::STAT_ADDR) begin
                s_d.rdata = bfu_pkg::DATA_RST;
                s_d.rdata[bfu_pkg::STAT_READY] = s_q.ready;
                s_d.rdata[bfu_pkg::STAT_BUSY]  = s_q.busy;
            end else begin
                s_d.rdata = bfu_pkg::DATA_RST;
            end
        end
        // access counting
        // done rises on the edge that clears busy, so ready and done
        // return together and a new op may follow at once
        if (s_q.busy) begin
            s_d.rem = s_q.rem - CNT_ONE;
            if (s_q.rem == CNT_ONE) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
        // operation execution, wins over the bus on the same target
        if (take) begin
            s_d.done = 1'b1;
            case (OP_CODE_I)
                bfu_pkg::ROTATE_RIGHT_CARRY_OP,
                bfu_pkg::ARITH_SHIFT_RIGHT_OP: begin
                    gpr_we = 1'b1;
                    gpr_wa = REG_SEL_I;
                    gpr_wd = sh_res;
                    s_d.result = sh_res;
                    s_d.flags[bfu_pkg::FLAG_C] = sh_c;
                    s_d.flags[bfu_pkg::FLAG_Z] = sh_z;
                    s_d.flags[bfu_pkg::FLAG_N] = sh_n;
                    s_d.flags[bfu_pkg::FLAG_V] = sh_v;
                end
                bfu_pkg::NIBBLE_SWAP_OP: begin
                    gpr_we = 1'b1;
                    gpr_wa = REG_SEL_I;
                    gpr_wd = sh_res;
                    s_d.result = sh_res;
                end
                bfu_pkg::IO_BIT_SET_OP,
                bfu_pkg::IO_BIT_CLEAR_OP: begin
                    io_we = 1'b1;
                    io_wa = IO_ADDR_I;
                    io_wd = io_opnd;
                    io_wd[BIT_SEL_I] = (OP_CODE_I == bfu_pkg::IO_BIT_SET_OP);
                    s_d.result = io_wd;
                end
                bfu_pkg::BIT_TO_TRANSFER_OP: begin
                    s_d.flags[bfu_pkg::FLAG_T] = gpr_opnd[BIT_SEL_I];
                end
                bfu_pkg::TRANSFER_TO_BIT_OP: begin
                    gpr_we = 1'b1;
                    gpr_wa = REG_SEL_I;
                    gpr_wd = gpr_opnd;
                    gpr_wd[BIT_SEL_I] = s_q.flags[bfu_pkg::FLAG_T];
                    s_d.result = gpr_wd;
                end
                bfu_pkg::FLAG_SET_OP: begin
                    s_d.flags[BIT_SEL_I] = 1'b1;
                end
                bfu_pkg::FLAG_CLEAR_OP: begin
                    s_d.flags[BIT_SEL_I] = 1'b0;
                end
                bfu_pkg::OVERFLOW_SET_OP: begin
                    s_d.flags[bfu_pkg::FLAG_V] = 1'b1;
                end
                bfu_pkg::OVERFLOW_CLEAR_OP: begin
                    s_d.flags[bfu_pkg::FLAG_V] = 1'b0;
                end
                bfu_pkg::HALF_CARRY_SET_OP: begin
                    s_d.flags[bfu_pkg::FLAG_H] = 1'b1;
                end
                bfu_pkg::HALF_CARRY_CLEAR_OP: begin
                    s_d.flags[bfu_pkg::FLAG_H] = 1'b0;
                end
                bfu_pkg::SIGNED_TEST_SET_OP: begin
                    s_d.flags[bfu_pkg::FLAG_S] = 1'b1;
                end
                bfu_pkg::SIGNED_TEST_CLEAR_OP: begin
                    s_d.flags[bfu_pkg::FLAG_S] = 1'b0;
                end
                bfu_pkg::DATA_ACCESS_OP: begin
                    // one cycle accesses finish at once, longer ones count
                    if (acc_cnt > CNT_ONE) begin
                        s_d.done = 1'b0;
                        s_d.busy = 1'b1;
                        s_d.rem  = acc_cnt - CNT_ONE;
                    end
                end
                default: begin
                    s_d.done = 1'b1;                                // nop still completes
                end
            endcase
        end
        s_d.ready = !s_d.busy;
    end

    // state register
    // memories clear with the unit, so operands read zero after reset
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            s_q <= '{flags:  bfu_pkg::FLAG_RST,
                     busy:   1'b0,
                     rem:    '0,
                     ready:  1'b1,
                     done:   1'b0,
                     result: bfu_pkg::DATA_RST,
                     rdata:  bfu_pkg::DATA_RST};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign READY_O  = s_q.ready;
    assign DONE_O   = s_q.done;
    assign RESULT_O = s_q.result;
    assign FLAGS_O  = s_q.flags;
    assign RDATA_O  = s_q.rdata;

endmodule : bfu_top
`default_nettype wire

// ==== tb/bfu_top_asserts.sv ====
// assertion checker for the bit and flag instruction unit
`timescale 1ns/1ps
`default_nettype none
module bfu_asserts (
    input wire logic                 CLK_I,
    input wire logic                 RESET_I,
    input wire logic                 OP_VALID_I,
    input wire bfu_pkg::bfu_op_t     OP_CODE_I,
    input wire logic           [2:0] BIT_SEL_I,
    input wire logic           [1:0] ACC_BASE_I,
    input wire bfu_pkg::bfu_target_t ACC_TGT_I,
    input wire logic                 WR_I,
    input wire logic                 READY_O,
    input wire logic                 DONE_O,
    input wire logic           [7:0] RESULT_O,
    input wire logic           [7:0] FLAGS_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);
    // op taken while no bus write can touch the flags
    logic tk;
    assign tk = OP_VALID_I && READY_O && !WR_I;
    chk_ror_carry_in:
    assert property (tk && OP_CODE_I == bfu_pkg::ROTATE_RIGHT_CARRY_OP |=> DONE_O
        && RESULT_O[7] == $past(FLAGS_O[0]) && FLAGS_O[3] == (FLAGS_O[2] ^ FLAGS_O[0]))
        else $error("rotate result or flags wrong");
    chk_asr_sign_kept:
    assert property (tk && OP_CODE_I == bfu_pkg::ARITH_SHIFT_RIGHT_OP |=> DONE_O
        && RESULT_O[7] == RESULT_O[6] && FLAGS_O[3] == (FLAGS_O[2] ^ FLAGS_O[0]))
        else $error("shift sign or flags wrong");
    chk_flags_untouched:
    assert property (tk && OP_CODE_I inside {bfu_pkg::NIBBLE_SWAP_OP, bfu_pkg::IO_BIT_SET_OP,
        bfu_pkg::IO_BIT_CLEAR_OP, bfu_pkg::TRANSFER_TO_BIT_OP} |=> DONE_O && $stable(FLAGS_O))
        else $error("flags changed by flagless op");
    chk_store_only_t:
    assert property (tk && OP_CODE_I == bfu_pkg::BIT_TO_TRANSFER_OP
        |=> (FLAGS_O & 8'hbf) == ($past(FLAGS_O) & 8'hbf)) else $error("store touched flags");
    chk_load_bit:
    assert property (tk && OP_CODE_I == bfu_pkg::TRANSFER_TO_BIT_OP
        |=> RESULT_O[$past(BIT_SEL_I)] == $past(FLAGS_O[6])) else $error("load bit wrong");
    chk_v_set_only:
    assert property (tk && OP_CODE_I == bfu_pkg::OVERFLOW_SET_OP
        |=> FLAGS_O == ($past(FLAGS_O) | 8'h08)) else $error("overflow set wrong");
    chk_h_clear_only:
    assert property (tk && OP_CODE_I == bfu_pkg::HALF_CARRY_CLEAR_OP
        |=> FLAGS_O == ($past(FLAGS_O) & 8'hdf)) else $error("half carry clear wrong");
    chk_sram_extra_cycle:
    assert property (tk && OP_CODE_I == bfu_pkg::DATA_ACCESS_OP && ACC_BASE_I == 2'h2
        && ACC_TGT_I == bfu_pkg::TGT_SRAM |=> !READY_O ##1 !READY_O ##1 (DONE_O && READY_O))
        else $error("sram access cycle count wrong");
endmodule : bfu_asserts
bind bfu_top bfu_asserts chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .OP_VALID_I(OP_VALID_I),
    .OP_CODE_I(OP_CODE_I), .BIT_SEL_I(BIT_SEL_I), .ACC_BASE_I(ACC_BASE_I), .WR_I(WR_I),
    .ACC_TGT_I(ACC_TGT_I), .READY_O(READY_O), .DONE_O(DONE_O), .RESULT_O(RESULT_O),
    .FLAGS_O(FLAGS_O));
`default_nettype wire

// ==== tb/bfu_top_tb.sv ====
// self-checking bench for the bit and flag instruction unit
`timescale 1ns/1ps
`default_nettype none
module bfu_top_tb;
    logic clk = 1'b0, rst = 1'b1, vld = 1'b0, wr = 1'b0, rd = 1'b0;
    bfu_pkg::bfu_op_t     code = bfu_pkg::NOP_OP;
    bfu_pkg::bfu_target_t tgt  = bfu_pkg::TGT_INTERNAL;
    logic [4:0] rsel = 5'h00;
    logic [2:0] bsel = 3'h0;
    logic [1:0] base = 2'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, result, flags, rdata;
    logic       ready, done;
    int         err_count = 0, checks = 0;
    bfu_top #(.EXT_EXTRA_CYCLES(2)) dut_u (.CLK_I(clk), .RESET_I(rst), .OP_VALID_I(vld),
        .OP_CODE_I(code), .REG_SEL_I(rsel), .BIT_SEL_I(bsel), .IO_ADDR_I(rsel),
        .ACC_BASE_I(base), .ACC_TGT_I(tgt), .READY_O(ready), .DONE_O(done),
        .RESULT_O(result), .FLAGS_O(flags), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata));
    // 40 MHz core clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : bus_rd
    // offer one op, count cycles from the taking edge to done
    task automatic run_op(input bfu_pkg::bfu_op_t c, input logic [4:0] r, input logic [2:0] b,
                          output int n);
        @(posedge clk);
        code <= c;
        rsel <= r;
        bsel <= b;
        vld  <= 1'b1;
        @(posedge clk);
        vld  <= 1'b0;
        n = 1;
        @(negedge clk);
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
    endtask : run_op
    task automatic t_shift;
        int n;
        logic [7:0] d;
        bus_wr(8'h03, 8'h81);
        bus_wr(bfu_pkg::FLAG_ADDR, 8'h01);
        run_op(bfu_pkg::ROTATE_RIGHT_CARRY_OP, 5'h03, 3'h0, n);
        chk8("ror result", 8'hc0, result);
        chk8("ror flags", 8'h05, flags);
        chk8("ror cycles", 8'h01, 8'(n));
        run_op(bfu_pkg::ARITH_SHIFT_RIGHT_OP, 5'h03, 3'h0, n);
        chk8("asr result", 8'he0, result);
        chk8("asr flags", 8'h0c, flags);
        run_op(bfu_pkg::NIBBLE_SWAP_OP, 5'h03, 3'h0, n);
        bus_rd(8'h03, d);
        chk8("swap reg", 8'h0e, d);
        chk8("swap flags", 8'h0c, flags);
    endtask : t_shift
    task automatic t_bits;
        int n;
        logic [7:0] d;
        bus_wr(8'h25, 8'h00);
        run_op(bfu_pkg::IO_BIT_SET_OP, 5'h05, 3'h7, n);
        run_op(bfu_pkg::IO_BIT_SET_OP, 5'h05, 3'h0, n);
        run_op(bfu_pkg::IO_BIT_CLEAR_OP, 5'h05, 3'h7, n);
        bus_rd(8'h25, d);
        chk8("io byte", 8'h01, d);
        chk8("io flags", 8'h0c, flags);
        run_op(bfu_pkg::BIT_TO_TRANSFER_OP, 5'h03, 3'h1, n);
        chk8("store flags", 8'h4c, flags);
        bus_wr(8'h04, 8'hf0);
        run_op(bfu_pkg::TRANSFER_TO_BIT_OP, 5'h04, 3'h2, n);
        chk8("load result", 8'hf4, result);
        chk8("load flags", 8'h4c, flags);
    endtask : t_bits
    // dedicated flag ops, each touching one bit only
    task automatic t_flags;
        int n;
        logic [7:0] e = 8'h44;
        logic [7:0] m [3] = '{8'h08, 8'h20, 8'h10};
        bfu_pkg::bfu_op_t ops [6] = '{bfu_pkg::OVERFLOW_SET_OP, bfu_pkg::HALF_CARRY_SET_OP,
            bfu_pkg::SIGNED_TEST_SET_OP, bfu_pkg::OVERFLOW_CLEAR_OP,
            bfu_pkg::HALF_CARRY_CLEAR_OP, bfu_pkg::SIGNED_TEST_CLEAR_OP};
        // start with v, h and s clear so every op moves its bit
        bus_wr(bfu_pkg::FLAG_ADDR, 8'h44);
        for (int i = 0; i < 6; i++) begin
            run_op(ops[i], 5'h00, 3'h0, n);
            e = (i < 3) ? (e | m[i % 3]) : (e & ~m[i % 3]);
            chk8("flag op", e, flags);
            chk8("flag cycles", 8'h01, 8'(n));
        end
        // generic flag set and clear by index
        run_op(bfu_pkg::FLAG_SET_OP, 5'h00, 3'h7, n);
        chk8("flag set by index", 8'hc4, flags);
        run_op(bfu_pkg::FLAG_CLEAR_OP, 5'h00, 3'h2, n);
        chk8("flag clear by index", 8'hc0, flags);
    endtask : t_flags
    // access length per target, external extra set to 2
    task automatic t_access;
        int n;
        logic [7:0] d;
        bfu_pkg::bfu_target_t tg [4] = '{bfu_pkg::TGT_SRAM, bfu_pkg::TGT_SRAM,
            bfu_pkg::TGT_INTERNAL, bfu_pkg::TGT_EXTERNAL};
        logic [1:0] bs [4] = '{2'h2, 2'h0, 2'h2, 2'h2};
        logic [7:0] ex [4] = '{8'h03, 8'h01, 8'h02, 8'h04};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            tgt  <= tg[i];
            base <= bs[i];
            run_op(bfu_pkg::DATA_ACCESS_OP, 5'h00, 3'h0, n);
            chk8("access cycles", ex[i], 8'(n));
        end
        // status byte while an external access counts, then idle
        @(posedge clk);
        code <= bfu_pkg::DATA_ACCESS_OP;
        vld  <= 1'b1;
        @(posedge clk);
        vld  <= 1'b0;
        bus_rd(bfu_pkg::STAT_ADDR, d);
        chk8("status busy", 8'h02, d);
        repeat (4) @(posedge clk);
        bus_rd(bfu_pkg::STAT_ADDR, d);
        chk8("status idle", 8'h01, d);
    endtask : t_access
    task automatic test_done;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    // watchdog well beyond the hundred or so cycles of the run
    initial begin
        #100000;
        err_count++;
        test_done();
    end
    initial begin
        logic [7:0] d;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk8("reset flags", bfu_pkg::FLAG_RST, flags);
        t_shift();
        t_bits();
        t_flags();
        t_access();
        bus_rd(8'h80, d);
        chk8("unmapped read", 8'h00, d);
        test_done();
    end
endmodule : bfu_top_tb
`default_nettype wire
